// *** src/swc_pkg.sv ***
/*
  Constants for the sleep and wake controller: register map, field
  positions, reset values, wake source count and timing counts.
  Assumes a 250 MHz main clock and a 32-bit APB register bus.
*/
// What this block does
// - Entering sleep clears the watchdog count; the watchdog keeps running.
// - Entering sleep clears the power-down flag.
// - Entering sleep sets the timeout flag.
// - Entering sleep switches the main oscillator driver off.
// - While asleep, port outputs are held at their pre-sleep state.
// - Wake on master clear, enabled watchdog timeout, or enabled interrupt.
// - Wake sources: pin, port B change and ten listed peripherals.
// - Other peripherals raise no interrupt while asleep.
// - Master clear fully resets; other wakes continue program execution.
// - Power-up sets the power-down flag.
// - A watchdog timeout wake clears the timeout flag.
// - The sleep instruction prefetches the instruction at PC plus 2.
// - Wake needs the source enable; global enable does not matter.
// - Global enable clear: continue after sleep, no vectoring.
// - Global enable set: run next instruction, then branch to vector.
// - Enabled interrupt already pending: sleep acts as no-operation.
// - Interrupt during or after sleep: sleep completes, then wakes at once.
// - Crystal mode waits 1024 oscillator periods on wake; RC/EC skip it.
// - Watchdog timeout resets when running, wakes when asleep.
// - With config enable clear, soft enable (reset 0) runs the watchdog.
package swc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NSRC   = 12;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CFG    = 12'h004;
  localparam logic [11:0] OFS_IRQEN  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;

  // Field positions.
  localparam int unsigned CTRL_SWDT  = 0;
  localparam int unsigned CTRL_GIE   = 1;
  localparam int unsigned CFG_CONFIG_WATCHDOG_ENABLE  = 0;
  localparam int unsigned CFG_PS_LO  = 1;
  localparam int unsigned CFG_XTAL   = 4;
  localparam int unsigned ST_PD      = 0;
  localparam int unsigned ST_TO      = 1;
  localparam int unsigned ST_ASLEEP  = 2;
  localparam int unsigned ST_WK_WDT  = 3;
  localparam int unsigned ST_WK_IRQ  = 4;

  // Reset values.
  localparam logic       RST_SWDT  = 1'h0;
  localparam logic       RST_GIE   = 1'h0;
  localparam logic       RST_CONFIG_WATCHDOG_ENABLE = 1'h1;
  localparam logic [2:0] RST_PS    = 3'h7;
  localparam logic       RST_XTAL  = 1'h1;

  // Oscillator start-up delay.
  localparam int unsigned OSC_PERIOD_PS  = 4000;
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned OST_PERIODS    = 1024;
  localparam int unsigned OST_CYCLES     =
    (OST_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [10:0] OST_LAST       = 11'(OST_CYCLES - 1);

  // Watchdog base count before the postscaler advances.
  localparam logic [7:0] WDT_BASE_LAST = 8'hff;
  localparam logic [7:0] WDT_POST_MAX  = 8'h80;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_OST,
    ST_POST
  } swc_state_e;

endpackage

// *** src/swc_top.sv ***
/*
  Sleep and wake controller: sleep entry, watchdog, wake detection,
  oscillator start-up delay and resume control, with an APB register file.
  Assumes the sequencer pulses sleep_exec, watchdog_clear_instr_exec and instr_done
  for one clock each, and that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module swc_top (
  input  wire logic                   clk,            // Main clock, 250 MHz
  input  wire logic                   rstn,           // Power-on reset, active low
  input  wire logic                   psel,           // APB select
  input  wire logic                   penable,        // APB enable
  input  wire logic                   pwrite,         // APB write
  input  wire logic [11:0]            paddr,          // APB byte address
  input  wire logic [31:0]            pwdata,         // APB write data
  output logic      [31:0]            prdata,         // APB read data
  output logic                        pready,         // APB ready
  output logic                        pslverr,        // APB error
  input  wire logic                   sleep_exec,     // Sleep instruction pulse
  input  wire logic                   watchdog_clear_instr_exec,    // Watchdog clear pulse
  input  wire logic                   instr_done,     // Instruction retired pulse
  input  wire logic                   master_clear_n, // Master clear pin, low active
  input  wire logic                   wdt_tick,       // Watchdog oscillator tick
  input  wire logic [11:0]            irq_flag,       // Wake source flags
  output logic                        osc_drive_en,   // Main oscillator driver on
  output logic                        core_run,       // Sequencer may run
  output logic                        port_hold,      // Freeze port outputs
  output logic                        prefetch_pc2,   // Fetch PC plus 2 pulse
  output logic                        resume_pulse,   // Execution resumes pulse
  output logic                        vector_req,     // Branch to vector pulse
  output logic                        device_reset,   // Full device reset pulse
  output logic                        powerdown_flag, // Power-down status flag
  output logic                        timeout_flag    // Timeout status flag
);

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic                 soft_wdt_en_r;
  logic                 gie_r;
  logic                 cfg_wdt_en_r;
  logic [2:0]           ps_r;
  logic                 xtal_r;
  logic [11:0]          irq_en_r;
  logic [31:0]          prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  swc_pkg::swc_state_e  state_r;
  swc_pkg::swc_state_e  state_nxt;
  logic                 pd_r;
  logic                 to_r;
  logic [7:0]           wdt_base_r;
  logic [6:0]           wdt_post_r;
  logic [10:0]          ost_cnt_r;
  logic                 vec_arm_r;
  logic                 wk_wdt_r;
  logic                 wk_irq_r;
  logic                 osc_r;
  logic                 run_r;
  logic                 hold_r;
  logic                 pref_r;
  logic                 resume_r;
  logic                 vec_r;
  logic                 rst_r;

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  // Index 0 is the external pin, 1 port B change, 2..11 the peripherals
  // that still work without the main clock. No other interrupt flag can wake.
  logic [11:0]          wake_src;

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_src
      assign wake_src[g] = irq_flag[g] & irq_en_r[g];
    end
  endgenerate

  // Pure gating, no clock involved, so a wake is seen while stopped.
  wire pending  = |wake_src;
  wire master_clear_pin     = ~master_clear_n;
  wire in_run   = (state_r == swc_pkg::ST_RUN);
  wire in_sleep = (state_r == swc_pkg::ST_SLEEP);

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  wire       wdt_on   = cfg_wdt_en_r | soft_wdt_en_r;
  wire [7:0] post_rat = swc_pkg::WDT_POST_MAX >> ps_r;
  wire [6:0] post_lim = 7'(post_rat - 8'h01);
  wire       base_end = (wdt_base_r == swc_pkg::WDT_BASE_LAST);
  wire       wdt_fire = wdt_on & wdt_tick & base_end
                        & (wdt_post_r == post_lim);

  // A pending enabled interrupt turns sleep into a no-operation.
  wire sleep_go = in_run & sleep_exec & ~pending
                  & ~master_clear_pin & ~wdt_fire;
  wire wdt_clr  = sleep_go | (in_run & watchdog_clear_instr_exec);
  wire wake_wdt = in_sleep & wdt_fire;
  wire wake_irq = in_sleep & pending & ~wdt_fire;
  wire wake_any = wake_wdt | wake_irq;

  wire [7:0] base_nxt =
    wdt_clr ? 8'h00 :
    (wdt_on & wdt_tick) ? 8'(wdt_base_r + 8'h01) : wdt_base_r;
  wire [6:0] post_nxt =
    (wdt_clr | wdt_fire) ? 7'h00 :
    (wdt_on & wdt_tick & base_end) ? 7'(wdt_post_r + 7'h01) : wdt_post_r;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  wire ost_end = (ost_cnt_r == swc_pkg::OST_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swc_pkg::ST_RUN: begin
        if (sleep_go) begin
          state_nxt = swc_pkg::ST_SLEEP;
        end
      end
      swc_pkg::ST_SLEEP: begin
        if (wake_any) begin
          // Only a crystal needs time to settle.
          state_nxt = xtal_r ? swc_pkg::ST_OST : swc_pkg::ST_POST;
        end
      end
      swc_pkg::ST_OST: begin
        if (ost_end) begin
          state_nxt = swc_pkg::ST_POST;
        end
      end
      swc_pkg::ST_POST: begin
        if (instr_done) begin
          state_nxt = swc_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = swc_pkg::ST_RUN;
      end
    endcase
    if (master_clear_pin) begin
      state_nxt = swc_pkg::ST_RUN;
    end
  end

  wire nxt_sleep = (state_nxt == swc_pkg::ST_SLEEP);
  wire nxt_ost   = (state_nxt == swc_pkg::ST_OST);

  // In crystal mode the wake path raises the driver before the sequencer sees run; otherwise both rise together.
  wire osc_nxt   = ~nxt_sleep;
  wire hold_nxt  = nxt_sleep | nxt_ost;
  wire run_nxt   = ~hold_nxt;

  // Clear wins over set: a watchdog fire in the same cycle blocks the sleep entry and clears the flag.
  wire to_nxt    = sleep_go ? 1'b1 :
                   wdt_fire ? 1'b0 : to_r;
  wire pd_nxt    = sleep_go ? 1'b0 : pd_r;
  wire [10:0] ost_nxt = (state_r == swc_pkg::ST_OST) ? 11'(ost_cnt_r + 11'h001) : 11'h000;

  wire post_end  = (state_r == swc_pkg::ST_POST) & instr_done & ~master_clear_pin;
  wire arm_nxt   = master_clear_pin ? 1'b0 :
                   wake_irq ? gie_r :
                   post_end ? 1'b0 : vec_arm_r;
  wire vec_nxt   = post_end & vec_arm_r;
  wire res_nxt   = ~master_clear_pin & (state_r != swc_pkg::ST_POST)
                   & (state_nxt == swc_pkg::ST_POST);
  wire rst_nxt   = master_clear_pin | (~in_sleep & wdt_fire);
  wire pref_nxt  = in_run & sleep_exec & ~master_clear_pin;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= swc_pkg::ST_RUN;
      pd_r       <= 1'b1;
      to_r       <= 1'b1;
      wdt_base_r <= 8'h00;
      wdt_post_r <= 7'h00;
      ost_cnt_r  <= 11'h000;
      vec_arm_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pd_r       <= pd_nxt;
      to_r       <= to_nxt;
      wdt_base_r <= base_nxt;
      wdt_post_r <= post_nxt;
      ost_cnt_r  <= ost_nxt;
      vec_arm_r  <= arm_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_r    <= 1'b1;
      run_r    <= 1'b1;
      hold_r   <= 1'b0;
      pref_r   <= 1'b0;
      resume_r <= 1'b0;
      vec_r    <= 1'b0;
      rst_r    <= 1'b0;
      wk_wdt_r <= 1'b0;
      wk_irq_r <= 1'b0;
    end else begin
      osc_r    <= osc_nxt;
      run_r    <= run_nxt;
      hold_r   <= hold_nxt;
      pref_r   <= pref_nxt;
      resume_r <= res_nxt;
      vec_r    <= vec_nxt;
      rst_r    <= rst_nxt;
      wk_wdt_r <= sleep_go ? 1'b0 : (wk_wdt_r | wake_wdt);
      wk_irq_r <= sleep_go ? 1'b0 : (wk_irq_r | wake_irq);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states: ready rises in the access phase.
  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pready_r & pwrite;
  wire hit_ctrl = (paddr == swc_pkg::OFS_CTRL);
  wire hit_cfg  = (paddr == swc_pkg::OFS_CFG);
  wire hit_en   = (paddr == swc_pkg::OFS_IRQEN);
  wire hit_st   = (paddr == swc_pkg::OFS_STATUS);
  wire mapped   = hit_ctrl | hit_cfg | hit_en | hit_st;
  // Status is read only; a write to it is refused with an error.
  wire bad      = ~mapped | (hit_st & pwrite);

  wire [31:0] rd_ctrl = {30'h0, gie_r, soft_wdt_en_r};
  wire [31:0] rd_cfg  = {27'h0, xtal_r, ps_r, cfg_wdt_en_r};
  wire [31:0] rd_en   = {20'h0, irq_en_r};
  wire [31:0] rd_st   = {27'h0, wk_irq_r, wk_wdt_r, in_sleep, to_r, pd_r};
  wire [31:0] rd_word = hit_ctrl ? rd_ctrl :
                        hit_cfg  ? rd_cfg  :
                        hit_en   ? rd_en   :
                        hit_st   ? rd_st   : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & bad;
      prdata_r  <= (setup & ~pwrite) ? rd_word : 32'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_wdt_en_r <= swc_pkg::RST_SWDT;
      gie_r         <= swc_pkg::RST_GIE;
      cfg_wdt_en_r  <= swc_pkg::RST_CONFIG_WATCHDOG_ENABLE;
      ps_r          <= swc_pkg::RST_PS;
      xtal_r        <= swc_pkg::RST_XTAL;
      irq_en_r      <= 12'h000;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        soft_wdt_en_r <= pwdata[swc_pkg::CTRL_SWDT];
        gie_r         <= pwdata[swc_pkg::CTRL_GIE];
      end
      if (hit_cfg) begin
        cfg_wdt_en_r <= pwdata[swc_pkg::CFG_CONFIG_WATCHDOG_ENABLE];
        ps_r         <= pwdata[swc_pkg::CFG_PS_LO +: 3];
        xtal_r       <= pwdata[swc_pkg::CFG_XTAL];
      end
      if (hit_en) begin
        irq_en_r <= pwdata[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign osc_drive_en   = osc_r;
  assign core_run       = run_r;
  assign port_hold      = hold_r;
  assign prefetch_pc2   = pref_r;
  assign resume_pulse   = resume_r;
  assign vector_req     = vec_r;
  assign device_reset   = rst_r;
  assign powerdown_flag = pd_r;
  assign timeout_flag   = to_r;

endmodule

// *** verification/swc_top_sva.sv ***
/*
  Port-level checker for the sleep and wake controller.
  Assumes it is bound to swc_top and that every input is synchronous to clk.
*/
`timescale 1ns/1ps
module swc_top_sva (
  input wire logic        clk,            // Main clock
  input wire logic        rstn,           // Reset, active low
  input wire logic        sleep_exec,     // Sleep pulse
  input wire logic        instr_done,     // Retire pulse
  input wire logic        master_clear_n, // Master clear pin
  input wire logic        wdt_tick,       // Watchdog tick
  input wire logic [11:0] irq_flag,       // Wake flags
  input wire logic        osc_drive_en,   // Oscillator on
  input wire logic        core_run,       // Sequencer runs
  input wire logic        port_hold,      // Ports frozen
  input wire logic        prefetch_pc2,   // Prefetch pulse
  input wire logic        resume_pulse,   // Resume pulse
  input wire logic        vector_req,     // Vector pulse
  input wire logic        device_reset,   // Reset pulse
  input wire logic        powerdown_flag, // Power-down flag
  input wire logic        timeout_flag    // Timeout flag
);
  // --------------------------------------------------------------
  // Start-up delay counter and properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Counts cycles with the oscillator back on while ports stay frozen.
  logic [10:0] ost_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ost_r <= 11'h000;
    else ost_r <= (osc_drive_en && port_hold) ? ost_r + 11'h001 : 11'h000;
  end

  property p_entry; sleep_exec && core_run && !port_hold && irq_flag == 12'h000 &&
    master_clear_n && !wdt_tick |=> !powerdown_flag && timeout_flag && !osc_drive_en &&
    port_hold && !core_run; endproperty
  a_entry: assert property (p_entry) else $error("sleep entry outputs wrong");
  property p_pref; sleep_exec && core_run && !port_hold && master_clear_n |=> prefetch_pc2;
  endproperty
  a_pref: assert property (p_pref) else $error("no prefetch after sleep");
  property p_hold; !osc_drive_en |-> port_hold && !core_run; endproperty
  a_hold: assert property (p_hold) else $error("ports not held while asleep");
  property p_ost; $fell(port_hold) && $past(master_clear_n) |->
    ost_r == 11'h000 || ost_r == 11'h400; endproperty
  a_ost: assert property (p_ost) else $error("start-up delay length wrong");
  property p_vec; vector_req |-> $past(instr_done); endproperty
  a_vec: assert property (p_vec) else $error("vector without retired instruction");
  property p_master_clear_pin; !master_clear_n |=> device_reset; endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear gave no reset");
  property p_mwake; port_hold && !master_clear_n |=> core_run && osc_drive_en && !port_hold;
  endproperty
  a_mwake: assert property (p_mwake) else $error("master clear did not wake");
  property p_pdfall; $fell(powerdown_flag) |-> $past(sleep_exec); endproperty
  a_pdfall: assert property (p_pdfall) else $error("power-down flag fell alone");
  property p_tofall; $fell(timeout_flag) |-> $past(wdt_tick) || $past(wdt_tick, 2); endproperty
  a_tofall: assert property (p_tofall) else $error("timeout flag fell alone");
  property p_resume; resume_pulse |-> core_run && osc_drive_en && !port_hold; endproperty
  a_resume: assert property (p_resume) else $error("resume before clock back");
endmodule

// *** verification/swc_seq_model.sv ***
/*
  Stand-in for the instruction sequencer that drives the controller.
  Assumes the bench pulses cmd_sleep for one clock while the core runs.
*/
`timescale 1ns/1ps
module swc_seq_model (
  input  wire logic       clk,          // Main clock
  input  wire logic       rstn,         // Reset, active low
  input  wire logic       cmd_sleep,    // Bench asks for a sleep
  input  wire logic [3:0] post_wait,    // Cycles to retire post-wake instruction
  input  wire logic       core_run,     // Sequencer may run
  input  wire logic       resume_pulse, // Execution resumes
  output logic            watchdog_clear_instr_exec,  // Watchdog clear pulse
  output logic            sleep_exec,   // Sleep pulse
  output logic            instr_done    // Retire pulse
);
  // --------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------
  logic [3:0] wait_r;
  // A clear always precedes the sleep so the watchdog starts from zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_clear_instr_exec <= 1'h0;
      sleep_exec  <= 1'h0;
      instr_done  <= 1'h0;
      wait_r      <= 4'h0;
    end else begin
      watchdog_clear_instr_exec <= cmd_sleep && core_run;
      sleep_exec  <= watchdog_clear_instr_exec;
      wait_r      <= resume_pulse ? post_wait : (wait_r != 4'h0 ? wait_r - 4'h1 : 4'h0);
      instr_done  <= wait_r == 4'h1;
    end
  end
endmodule

// *** verification/tb.sv ***
/*
  Self-checking bench for the sleep and wake controller.
  Assumes the design answers APB with one access cycle and no wait state.
*/
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        master_clear_n = 1, wdt_tick = 0, cmd_sleep = 0, e;
  logic [3:0]  post_wait = 4'h1;
  logic [11:0] paddr = 0, irq_flag = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, sleep_exec, watchdog_clear_instr_exec, instr_done, osc_drive_en, core_run;
  logic        port_hold, prefetch_pc2, resume_pulse, vector_req, device_reset;
  logic        powerdown_flag, timeout_flag;
  int          mismatches = 0, tests_run = 0, cyc = 0, n;

  always #2 clk = ~clk;

  swc_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_exec, .watchdog_clear_instr_exec, .instr_done, .master_clear_n, .wdt_tick,
    .irq_flag, .osc_drive_en, .core_run, .port_hold, .prefetch_pc2, .resume_pulse,
    .vector_req, .device_reset, .powerdown_flag, .timeout_flag);
  swc_seq_model model (.clk, .rstn, .cmd_sleep, .post_wait, .core_run, .resume_pulse,
    .watchdog_clear_instr_exec, .sleep_exec, .instr_done);

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    chk(e, 32'h0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'h0, a, 32'h0);
    chk(r, x);
    chk(e, xe);
  endtask

  task automatic wt(ref logic s, output int k);
    k = 0;
    while (s !== 1'b1) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic slp;
    cmd_sleep <= 1'h1;
    @(posedge clk);
    cmd_sleep <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk({powerdown_flag, timeout_flag, osc_drive_en, core_run, port_hold}, 32'h1e);
    rdc(swc_pkg::OFS_CTRL, 32'h0, 1'h0);
    rdc(swc_pkg::OFS_CFG, 32'h1f, 1'h0);
    rdc(12'h010, 32'h0, 1'h1);
    apb(1'h1, swc_pkg::OFS_STATUS, 32'h0);
    chk(e, 32'h1);
    rdc(swc_pkg::OFS_STATUS, 32'h3, 1'h0);
    $display("register test done");
    wr(swc_pkg::OFS_CFG, 32'he);
    wr(swc_pkg::OFS_IRQEN, 32'h4);
    irq_flag <= 12'h004;
    slp();
    chk({powerdown_flag, timeout_flag, core_run, port_hold}, 32'he);
    $display("pending wake test done");
    for (int i = 0; i < 12; i++) begin
      wr(swc_pkg::OFS_IRQEN, 32'h1 << i);
      irq_flag <= 12'h000;
      slp();
      chk({powerdown_flag, timeout_flag, osc_drive_en, core_run, port_hold}, 32'h9);
      irq_flag <= ~(12'h001 << i);
      repeat (4) @(posedge clk);
      chk(port_hold, 32'h1);
      irq_flag <= 12'hfff;
      wt(resume_pulse, n);
      chk(n < 8, 32'h1);
      wt(instr_done, n);
      @(posedge clk);
      chk(vector_req, 32'h0);
    end
    rdc(swc_pkg::OFS_STATUS, 32'h12, 1'h0);
    $display("source wake test done");
    irq_flag <= 12'h000;
    wr(swc_pkg::OFS_CTRL, 32'h2);
    wr(swc_pkg::OFS_CFG, 32'h1e);
    wr(swc_pkg::OFS_IRQEN, 32'h4);
    post_wait <= 4'h5;
    slp();
    irq_flag <= 12'h004;
    wt(resume_pulse, n);
    chk(n > 1024 && n < 1032, 32'h1);
    wt(instr_done, n);
    @(posedge clk);
    chk(vector_req, 32'h1);
    $display("crystal wake test done");
    irq_flag <= 12'h000;
    wr(swc_pkg::OFS_CTRL, 32'h0);
    wr(swc_pkg::OFS_CFG, 32'hf);
    slp();
    wdt_tick <= 1'h1;
    wt(resume_pulse, n);
    chk(n >= 256 && n < 264, 32'h1);
    chk(timeout_flag, 32'h0);
    wt(instr_done, n);
    rdc(swc_pkg::OFS_STATUS, 32'h8, 1'h0);
    wt(device_reset, n);
    chk(n > 230 && n < 260, 32'h1);
    // With both enables off the count must freeze; a still-running one resets far too early.
    wr(swc_pkg::OFS_CFG, 32'he);
    repeat (100) @(posedge clk);
    wr(swc_pkg::OFS_CTRL, 32'h1);
    wt(device_reset, n);
    chk(n > 240 && n < 260, 32'h1);
    wdt_tick <= 1'h0;
    $display("watchdog test done");
    wr(swc_pkg::OFS_CFG, 32'he);
    slp();
    master_clear_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk(device_reset, 32'h1);
    master_clear_n <= 1'h1;
    @(posedge clk);
    chk({core_run, osc_drive_en, port_hold, powerdown_flag}, 32'hc);
    $display("master clear test done");
    end_of_test();
  end
endmodule

bind swc_top swc_top_sva u_sva (.clk, .rstn, .sleep_exec, .instr_done, .master_clear_n,
  .wdt_tick, .irq_flag, .osc_drive_en, .core_run, .port_hold, .prefetch_pc2, .resume_pulse,
  .vector_req, .device_reset, .powerdown_flag, .timeout_flag);
